// ===== include/logic_blocks_consts.svh
// Constants for the scan-driven bit logic elements
`ifndef LOGIC_BLOCKS_CONSTS_SVH
`define LOGIC_BLOCKS_CONSTS_SVH

// System clock and scan timing
`define CLK_PERIOD_NS   20
`define SCAN_TIME_US    1000
`define SCAN_CYCLES     ((`SCAN_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SCAN_CNT_W      16

// Expression program geometry
`define PROG_LEN        8
`define STACK_DEPTH     4
`define SP_W            4

// Reset values of stored states
`define STATE_LOW       1'b0
`define CNT_ZERO        16'h0000

`endif

// ===== include/logic_blocks_pkg.sv
// Types shared by the scan-driven bit logic elements
`default_nettype none
`include "logic_blocks_consts.svh"

package logic_blocks_pkg;

  // One step of a postfix expression program
  typedef enum logic [3:0] {
    TOK_END,
    TOK_IN1,
    TOK_IN2,
    TOK_IN3,
    TOK_IN4,
    TOK_AND,
    TOK_OR,
    TOK_XOR,
    TOK_NOT
  } token_t;

  typedef enum logic {
    PRIO_SET,
    PRIO_RESET
  } latch_priority_t;

  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } pulse_mode_t;

  typedef struct packed {
    token_t [`PROG_LEN-1:0] steps;
    latch_priority_t        latch_priority;
    pulse_mode_t            pulse_mode;
  } block_cfg_t;

  typedef struct packed {
    logic set;
    logic reset;
  } latch_in_t;

  typedef struct packed {
    logic in;
    logic clear;
  } toggle_in_t;

endpackage

`default_nettype wire

// ===== logic/basic_logic_function_blocks.sv
// Scan-driven bit logic elements: expression, latch, edge pulse, toggle

`timescale 1ns/1ps
`default_nettype none
`include "logic_blocks_consts.svh"

module basic_logic_function_blocks
  import logic_blocks_pkg::*;
#(
  parameter int SCAN_CYCLES = `SCAN_CYCLES
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,

  // Configuration, held steady by the controller
  input  wire block_cfg_t cfg,

  // Expression element inputs 1 to 4
  input  wire logic [3:0] expr_in,

  // Latch, pulse and toggle inputs
  input  wire latch_in_t  latch_in,
  input  wire logic       pulse_in,
  input  wire toggle_in_t toggle_in,

  // Results
  output logic            expr_out,
  output logic            expr_fault,
  output logic            latch_out,
  output logic            pulse_out,
  output logic            toggle_out,
  output logic            scan_tick
);

  // Scan rate divider

  logic [`SCAN_CNT_W-1:0] scan_count;
  logic                   scan_last;

  assign scan_last = (scan_count == (`SCAN_CNT_W)'(SCAN_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scan_count <= `CNT_ZERO;
    end
    else if (scan_last)
    begin
      scan_count <= `CNT_ZERO;
    end
    else
    begin
      scan_count <= scan_count + (`SCAN_CNT_W)'(1);
    end
  end

  // Registered copy of the scan enable, for elements downstream
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scan_tick <= `STATE_LOW;
    end
    else
    begin
      scan_tick <= scan_last;
    end
  end

  // Expression element: a postfix program walked over a small stack.
  // Parentheses of the infix form become step order, so any grouping
  // that fits the stack depth and the eight program steps can be expressed.

  logic                    next_expr_value;
  logic                    next_expr_fault;

  always_comb
  begin
    logic [`STACK_DEPTH-1:0] stack;
    logic [`SP_W-1:0]        sp;
    logic                    done;
    logic                    bad;
    logic                    a;
    logic                    b;
    stack = '0;
    sp    = '0;
    done  = 1'b0;
    bad   = 1'b0;
    a     = 1'b0;
    b     = 1'b0;
    for (int i = 0; i < `PROG_LEN; i++)
    begin
      if (!done && !bad)
      begin
        case (cfg.steps[i])
          TOK_END:
          begin
            done = 1'b1;
          end
          TOK_IN1, TOK_IN2, TOK_IN3, TOK_IN4:
          begin
            if (sp == (`SP_W)'(`STACK_DEPTH))
            begin
              bad = 1'b1;
            end
            else
            begin
              case (cfg.steps[i])
                TOK_IN1: a = expr_in[0];
                TOK_IN2: a = expr_in[1];
                TOK_IN3: a = expr_in[2];
                default: a = expr_in[3];
              endcase
              stack[sp[1:0]] = a;
              sp = sp + (`SP_W)'(1);
            end
          end
          TOK_NOT:
          begin
            if (sp == '0)
            begin
              bad = 1'b1;
            end
            else
            begin
              stack[sp[1:0] - 2'd1] = ~stack[sp[1:0] - 2'd1];
            end
          end
          TOK_AND, TOK_OR, TOK_XOR:
          begin
            if (sp < (`SP_W)'(2))
            begin
              bad = 1'b1;
            end
            else
            begin
              a = stack[sp[1:0] - 2'd2];
              b = stack[sp[1:0] - 2'd1];
              case (cfg.steps[i])
                TOK_AND: a = a & b;
                TOK_OR:  a = a | b;
                default: a = a ^ b;
              endcase
              stack[sp[1:0] - 2'd2] = a;
              sp = sp - (`SP_W)'(1);
            end
          end
          default:
          begin
            bad = 1'b1;
          end
        endcase
      end
    end
    // A program must leave exactly one value behind
    if (sp != (`SP_W)'(1))
    begin
      bad = 1'b1;
    end
    next_expr_fault = bad;
    next_expr_value = bad ? `STATE_LOW : stack[0];
  end

  // The result itself is deliberately not registered: the expression
  // is pure combinational logic from its inputs to its output.
  assign expr_out = next_expr_value;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      expr_fault <= `STATE_LOW;
    end
    else
    begin
      expr_fault <= next_expr_fault;
    end
  end

  // Priority latch

  logic next_latch;

  always_comb
  begin
    next_latch = latch_out;
    if (latch_in.set && latch_in.reset)
    begin
      next_latch = (cfg.latch_priority == PRIO_SET);
    end
    else if (latch_in.set)
    begin
      next_latch = 1'b1;
    end
    else if (latch_in.reset)
    begin
      next_latch = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latch_out <= `STATE_LOW;
    end
    else if (scan_last)
    begin
      latch_out <= next_latch;
    end
  end

  // Edge pulse element

  logic pulse_prev;
  logic next_pulse;

  always_comb
  begin
    case (cfg.pulse_mode)
      EDGE_RISE: next_pulse = pulse_in & ~pulse_prev;
      EDGE_FALL: next_pulse = ~pulse_in & pulse_prev;
      EDGE_BOTH: next_pulse = pulse_in ^ pulse_prev;
      default:   next_pulse = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pulse_prev <= `STATE_LOW;
    end
    else if (scan_last)
    begin
      pulse_prev <= pulse_in;
    end
  end

  // Written every scan, so a pulse drops at the following scan tick
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pulse_out <= `STATE_LOW;
    end
    else if (scan_last)
    begin
      pulse_out <= next_pulse;
    end
  end

  // Toggle element

  logic toggle_prev;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      toggle_prev <= `STATE_LOW;
    end
    else if (scan_last)
    begin
      toggle_prev <= toggle_in.in;
    end
  end

  // Clear is checked first so it wins over a rising input in the same scan
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      toggle_out <= `STATE_LOW;
    end
    else if (scan_last)
    begin
      if (toggle_in.clear)
      begin
        toggle_out <= `STATE_LOW;
      end
      else if (toggle_in.in && !toggle_prev)
      begin
        toggle_out <= ~toggle_out;
      end
    end
  end

endmodule // basic_logic_function_blocks

`default_nettype wire

// ===== testbench/basic_logic_function_blocks_checker.sv
// Port assertions for the scan-driven bit logic elements
`timescale 1ns/1ps
`default_nettype none
module basic_logic_function_blocks_checker
  import logic_blocks_pkg::*;
#(
  parameter int SCAN_CYCLES = 4
)
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Watched ports
  input wire block_cfg_t cfg,
  input wire logic [3:0] expr_in,
  input wire latch_in_t  latch_in,
  input wire logic       pulse_in,
  input wire toggle_in_t toggle_in,
  input wire logic       expr_out,
  input wire logic       expr_fault,
  input wire logic       latch_out,
  input wire logic       pulse_out,
  input wire logic       toggle_out,
  input wire logic       scan_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // With scan_tick high, outputs show the scan taken one edge earlier
  sequence s_set;
    scan_tick && $past(latch_in.set) && !$past(latch_in.reset);
  endsequence
  sequence s_rst;
    scan_tick && !$past(latch_in.set) && $past(latch_in.reset);
  endsequence
  sequence s_both;
    scan_tick && $past(latch_in.set) && $past(latch_in.reset);
  endsequence
  a_latch_set: assert property (s_set |-> latch_out)
    else $error("latch not set");
  a_latch_reset: assert property (s_rst |-> !latch_out)
    else $error("latch not reset");
  a_latch_both: assert property (s_both |-> latch_out == (cfg.latch_priority == PRIO_SET))
    else $error("latch priority wrong");
  a_latch_hold: assert property (scan_tick && !$past(latch_in) |-> $stable(latch_out))
    else $error("latch lost state");
  a_state_between: assert property (!scan_tick |-> $stable({latch_out, pulse_out, toggle_out}))
    else $error("state moved off scan");
  a_toggle_clear: assert property (scan_tick && $past(toggle_in.clear) |-> !toggle_out)
    else $error("toggle not cleared");
  a_toggle_flip: assert property (scan_tick && !$past(toggle_in.clear) |-> toggle_out == ($past(toggle_out) ^
    ($past(toggle_in.in) && !$past(toggle_in.in, SCAN_CYCLES + 1))))
    else $error("toggle state wrong");
  a_pulse_edge: assert property (scan_tick |-> pulse_out ==
    ((cfg.pulse_mode != EDGE_FALL && $past(pulse_in) && !$past(pulse_in, SCAN_CYCLES + 1)) ||
     (cfg.pulse_mode != EDGE_RISE && !$past(pulse_in) && $past(pulse_in, SCAN_CYCLES + 1))))
    else $error("pulse output wrong");
  // Fault flag lags a program change by one clock, so only a settled program is judged
  a_fault_zero: assert property (expr_fault && $stable(cfg) |-> !expr_out)
    else $error("faulty expression not zero");
endmodule // basic_logic_function_blocks_checker

bind basic_logic_function_blocks basic_logic_function_blocks_checker #(.SCAN_CYCLES(SCAN_CYCLES)) u_chk (
  .clk(clk), .reset_n(reset_n), .cfg(cfg), .expr_in(expr_in), .latch_in(latch_in), .pulse_in(pulse_in),
  .toggle_in(toggle_in), .expr_out(expr_out), .expr_fault(expr_fault), .latch_out(latch_out),
  .pulse_out(pulse_out), .toggle_out(toggle_out), .scan_tick(scan_tick));
`default_nettype wire

// ===== testbench/tb_basic_logic_function_blocks.sv
// Self-checking bench for the scan-driven bit logic elements
`timescale 1ns/1ps
`default_nettype none
module tb_basic_logic_function_blocks;
  import logic_blocks_pkg::*;
  localparam int SCAN = 4;
  logic       clk;
  logic       reset_n;
  block_cfg_t cfg;
  logic [3:0] expr_in;
  latch_in_t  latch_in;
  logic       pulse_in;
  toggle_in_t toggle_in;
  logic       expr_out;
  logic       expr_fault;
  logic       latch_out;
  logic       pulse_out;
  logic       toggle_out;
  logic       scan_tick;
  int         n_errors;
  int         checks;

  basic_logic_function_blocks #(.SCAN_CYCLES(SCAN)) u_basic_logic_function_blocks (
    .clk(clk), .reset_n(reset_n), .cfg(cfg), .expr_in(expr_in), .latch_in(latch_in), .pulse_in(pulse_in),
    .toggle_in(toggle_in), .expr_out(expr_out), .expr_fault(expr_fault), .latch_out(latch_out),
    .pulse_out(pulse_out), .toggle_out(toggle_out), .scan_tick(scan_tick));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [2:0] exp, input logic [2:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Returns just after the edge that shows a finished scan
  task automatic wait_scan;
    for (int i = 0; i < 3 * SCAN; i++)
    begin
      @(posedge clk);
      #1;
      if (scan_tick === 1'b1)
        return;
    end
    n_errors++;
    $display("Error scan_tick expected 1 seen 0");
  endtask

  // ins: set, reset, pulse, toggle in, clear; exp: latch, pulse, toggle
  task automatic step(input logic [4:0] ins, input logic [2:0] exp);
    {latch_in, pulse_in, toggle_in} = ins;
    wait_scan();
    check("outputs", exp, {latch_out, pulse_out, toggle_out});
  endtask

  task automatic load(input token_t t [6]);
    for (int i = 0; i < 8; i++)
      cfg.steps[i] = (i < 6) ? t[i] : TOK_END;
  endtask

  task automatic t_expr;
    for (int i = 0; i < 32; i++)
    begin
      logic want;
      @(posedge clk);
      #1;
      if (i == 16)
        load('{TOK_IN1, TOK_IN4, TOK_XOR, TOK_NOT, TOK_END, TOK_END});
      expr_in = i[3:0];
      want = (i < 16) ? ((expr_in[0] & expr_in[1]) | expr_in[2]) : !(expr_in[0] ^ expr_in[3]);
      #1;
      check("expr_out", 3'(want), 3'(expr_out));
    end
    // Five pushes overrun the four-deep stack
    @(posedge clk);
    #1;
    load('{TOK_IN1, TOK_IN2, TOK_IN3, TOK_IN4, TOK_IN1, TOK_END});
    @(posedge clk);
    #1;
    check("expr_fault", 3'b010, 3'({expr_fault, expr_out}));
  endtask

  task automatic t_latch;
    step(5'b10000, 3'b100);
    step(5'b00000, 3'b100);
    step(5'b11000, 3'b100);
    step(5'b01000, 3'b000);
    cfg.latch_priority = PRIO_RESET;
    step(5'b10000, 3'b100);
    step(5'b11000, 3'b000);
    latch_in = 2'b10;
    @(posedge clk);
    #1;
    step(5'b00000, 3'b000);
  endtask

  task automatic t_pulse;
    for (int m = 0; m < 3; m++)
    begin
      cfg.pulse_mode = pulse_mode_t'(m);
      step(5'b00100, {1'b0, m != 1, 1'b0});
      step(5'b00100, 3'b000);
      step(5'b00000, {1'b0, m != 0, 1'b0});
      step(5'b00000, 3'b000);
    end
  endtask

  task automatic t_toggle;
    step(5'b00010, 3'b001);
    step(5'b00010, 3'b001);
    step(5'b00011, 3'b000);
    step(5'b00000, 3'b000);
    step(5'b00011, 3'b000);
    step(5'b00010, 3'b000);
    step(5'b00000, 3'b000);
    step(5'b00010, 3'b001);
  endtask

  initial
  begin
    reset_n = 1'b0;
    cfg = '0;
    load('{TOK_IN1, TOK_IN2, TOK_AND, TOK_IN3, TOK_OR, TOK_END});
    expr_in = 4'h0;
    latch_in = '0;
    pulse_in = 1'b0;
    toggle_in = '0;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check("reset", 3'b000, {latch_out, pulse_out, toggle_out});
    t_expr();
    wait_scan();
    t_latch();
    t_pulse();
    t_toggle();
    wrap_up();
  end

  // Whole run needs about 160 clocks
  initial
  begin
    #100000;
    n_errors++;
    $display("Error watchdog expected done seen timeout");
    wrap_up();
  end
endmodule // tb_basic_logic_function_blocks
`default_nettype wire
